/* rtl/spsi_pkg.sv */
// package of the serial port select and two-wire slave front end
// assumes nothing beyond a SystemVerilog elaborator
`default_nettype none

package spsi_pkg;

  // slave address: fixed upper nibble, strap-coded lower three bits
  localparam logic [3:0] SLAVE_ADDR_MSB = 4'hb;
  localparam int SLAVE_ADDR_W = 7;
  localparam int STRAP_IDX_W = 4;

  // three-level strap encoding as presented by the pad comparators
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [3:0] STRAP_LEVELS = 4'h3;
  // high/high selects the four-wire port
  localparam logic [3:0] STRAP_IDX_SPI = 4'h8;

  // byte framing
  localparam int REG_ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] TX_BIT_LAST = 4'h7;
  localparam logic RW_READ = 1'b1;
  localparam logic [15:0] REG_ADDR_STEP = 16'h0001;

  // bus rates and sampling margin
  localparam int SCL_STD_KHZ = 100;
  localparam int SCL_FAST_KHZ = 400;
  localparam int STD_SCL_PERIOD_NS = 1000000 / SCL_STD_KHZ;
  localparam int FAST_SCL_PERIOD_NS = 1000000 / SCL_FAST_KHZ;
  localparam int LINK_CLK_MHZ_DEF = 66;
  localparam int MIN_QTR_SAMPLES = 4;

  // transaction phase within one start..stop frame
  typedef enum logic [1:0] {
    PH_SLAVE = 2'h0,
    PH_ADDR_HI = 2'h1,
    PH_ADDR_LO = 2'h2,
    PH_DATA = 2'h3
  } spsi_phase_t;

  // slave state, gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX = 3'h1,
    ST_RX_ACK = 3'h3,
    ST_TX = 3'h2,
    ST_TX_ACK = 3'h6
  } spsi_state_t;

endpackage

`default_nettype wire

/* rtl/spsi_xfer_if.sv */
// carrier between the link-side slave and the system-side bridge
// request words are held stable while their toggle is in flight
`default_nettype none

interface spsi_xfer_if;
  import spsi_pkg::*;

  logic req_tgl;
  logic req_we;
  logic [REG_ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata;
  logic ack_tgl;
  logic [DATA_W-1:0] ack_rdata;
  logic spi_mode;

  modport link (
    output req_tgl, req_we, req_addr, req_wdata, spi_mode,
    input ack_tgl, ack_rdata
  );

  modport sys (
    input req_tgl, req_we, req_addr, req_wdata, spi_mode,
    output ack_tgl, ack_rdata
  );

endinterface

`default_nettype wire

/* rtl/spsi_strap_dec.sv */
// strap decoder: port select and slave address from two three-level pins
// runs on the link clock; straps are caught once after link reset release
`default_nettype none

module spsi_strap_dec (
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic [1:0] port_strap_high,
  input wire logic [1:0] port_strap_low,
  output logic [spsi_pkg::SLAVE_ADDR_W-1:0] slave_addr,
  output logic spi_mode
);
  import spsi_pkg::*;

  typedef struct packed {
    logic [1:0] hi_m;
    logic [1:0] hi_s;
    logic [1:0] lo_m;
    logic [1:0] lo_s;
    logic caught;
    logic [SLAVE_ADDR_W-1:0] addr;
    logic spi;
  } spsi_strap_t;

  spsi_strap_t r;
  spsi_strap_t n;

  // level to number: low 0, open 1, high 2; an illegal code reads open
  function automatic logic [3:0] lvl_num(input logic [1:0] lvl);
    logic [3:0] v;
    v = 4'h1;
    if (lvl == STRAP_LOW) begin
      v = 4'h0;
    end else if (lvl == STRAP_HIGH) begin
      v = 4'h2;
    end
    return v;
  endfunction

  // synchronise the pads, then latch the decoded selection once
  always_comb begin
    logic [3:0] idx;
    idx = 4'((lvl_num(r.hi_s) * STRAP_LEVELS) + lvl_num(r.lo_s));
    n = r;
    n.hi_m = port_strap_high;
    n.hi_s = r.hi_m;
    n.lo_m = port_strap_low;
    n.lo_s = r.lo_m;
    if (link_rst) begin
      n.caught = 1'b0;
      n.addr = '0;
      n.spi = 1'b0;
    end else if (!r.caught) begin
      n.caught = 1'b1;
      n.spi = (idx == STRAP_IDX_SPI);
      n.addr = {SLAVE_ADDR_MSB, idx[2:0]};
    end
  end

  always_ff @(posedge link_clk) begin
    r <= n;
  end

  assign slave_addr = r.addr;
  assign spi_mode = r.spi;

endmodule

`default_nettype wire

/* rtl/spsi_cfg_bridge.sv */
// system-side bridge: turns link requests into configuration accesses
// assumes cfg_ack answers each cfg_req; the sleep pin is synchronised here
`default_nettype none

module spsi_cfg_bridge (
  input wire logic sys_clk,
  input wire logic rst,
  spsi_xfer_if.sys x,
  input wire logic sleep_request_n,
  output logic spi_select,
  output logic sleep_active,
  output logic cfg_req,
  output logic cfg_we,
  output logic [spsi_pkg::REG_ADDR_W-1:0] cfg_addr,
  output logic [spsi_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic [spsi_pkg::DATA_W-1:0] cfg_rdata,
  input wire logic cfg_ack
);
  import spsi_pkg::*;

  typedef struct packed {
    logic rq_m;
    logic rq_s;
    logic rq_seen;
    logic sp_m;
    logic sp_s;
    logic sl_m;
    logic sl_s;
    logic busy;
    logic we;
    logic [REG_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic ack_tgl;
  } spsi_brg_t;

  spsi_brg_t r;
  spsi_brg_t n;

  // toggle handshake in, one configuration access, toggle handshake out
  always_comb begin
    n = r;
    n.rq_m = x.req_tgl;
    n.rq_s = r.rq_m;
    n.sp_m = x.spi_mode;
    n.sp_s = r.sp_m;
    n.sl_m = ~sleep_request_n; // high while asleep, same sense as the reset value
    n.sl_s = r.sl_m;
    if (rst) begin
      n = '0;
    end else if (!r.busy && (r.rq_s != r.rq_seen)) begin
      n.busy = 1'b1;
      n.rq_seen = r.rq_s;
      n.we = x.req_we;
      n.addr = x.req_addr;
      n.wdata = x.req_wdata;
    end else if (r.busy && cfg_ack) begin
      n.busy = 1'b0;
      n.rdata = r.we ? r.wdata : cfg_rdata;
      n.ack_tgl = ~r.ack_tgl;
    end
  end

  always_ff @(posedge sys_clk) begin
    r <= n;
  end

  // outputs straight from the state
  assign cfg_req = r.busy;
  assign cfg_we = r.we;
  assign cfg_addr = r.addr;
  assign cfg_wdata = r.wdata;
  assign x.ack_tgl = r.ack_tgl;
  assign x.ack_rdata = r.rdata;
  assign spi_select = r.sp_s;
  assign sleep_active = r.sl_s;

endmodule

`default_nettype wire

/* rtl/spsi_i2c_slave.sv */
// serial port select and two-wire slave: top of the control port front end
// link logic runs on link_clk, configuration access on sys_clk
// Function
// - four-wire port only when both straps high
// - slave address upper four bits are 1011b
// - strap pair decodes into eight slave addresses
// - works at 100 kHz and 400 kHz
// - slave only, never drives the clock line
// - register address is two bytes, sixteen bits
// - data changes only while clock low
// - falling data with clock high starts transaction
// - rising data with clock high ends transaction
// - eight-bit bytes, MSB first, then acknowledge bit
// - acknowledge by holding data low on ninth pulse
// - no-acknowledge leaves data high on ninth pulse
// - master reads and writes every configuration register
// - port keeps working while chip sleeps
// - first byte is address plus direction bit
// - write sends address high, low, then data bytes
// - master no-acknowledges last read byte, slave releases
// - start or stop anywhere discards partial byte
`default_nettype none

module spsi_i2c_slave #(
  parameter int LINK_CLK_MHZ = spsi_pkg::LINK_CLK_MHZ_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] port_strap_high,
  input wire logic [1:0] port_strap_low,
  input wire logic sleep_request_n,
  output logic spi_select,
  output logic sleep_active,
  output logic cfg_req,
  output logic cfg_we,
  output logic [spsi_pkg::REG_ADDR_W-1:0] cfg_addr,
  output logic [spsi_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic [spsi_pkg::DATA_W-1:0] cfg_rdata,
  input wire logic cfg_ack
);
  import spsi_pkg::*;

  // link clock must see every quarter of a fast bus period several times
  localparam int FAST_QTR_CYC = (FAST_SCL_PERIOD_NS * LINK_CLK_MHZ) / 4000;
  localparam int STD_QTR_CYC = (STD_SCL_PERIOD_NS * LINK_CLK_MHZ) / 4000;

  generate
    if (FAST_QTR_CYC < MIN_QTR_SAMPLES || STD_QTR_CYC < MIN_QTR_SAMPLES) begin : g_chk
      $error("link clock too slow to sample the two-wire bus");
    end
  endgenerate

  typedef struct packed {
    logic rs_m;
    logic rs_s;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic ack_m;
    logic ack_s;
    logic ack_p;
    spsi_state_t st;
    spsi_phase_t ph;
    logic [3:0] bitc;
    logic rw;
    logic [DATA_W-1:0] shf;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] rd_buf;
    logic drive;
    logic req_tgl;
    logic req_we;
    logic [REG_ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata;
  } spsi_link_t;

  spsi_link_t r;
  spsi_link_t n;

  logic link_rst;
  logic [SLAVE_ADDR_W-1:0] slave_addr;
  logic spi_mode;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  spsi_xfer_if x ();

  // strap decode on the link side, where the address is compared
  spsi_strap_dec u_strap (
    .link_clk(link_clk),
    .link_rst(link_rst),
    .port_strap_high(port_strap_high),
    .port_strap_low(port_strap_low),
    .slave_addr(slave_addr),
    .spi_mode(spi_mode)
  );

  // configuration access and sleep sync on the system side
  spsi_cfg_bridge u_bridge (
    .sys_clk(sys_clk),
    .rst(rst),
    .x(x),
    .sleep_request_n(sleep_request_n),
    .spi_select(spi_select),
    .sleep_active(sleep_active),
    .cfg_req(cfg_req),
    .cfg_we(cfg_we),
    .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack)
  );

  // bus events from the synchronised pins; the sleep level gates nothing
  assign link_rst = r.rs_s;
  assign scl_rise = r.scl_s && !r.scl_p;
  assign scl_fall = !r.scl_s && r.scl_p;
  assign start_seen = r.scl_s && r.scl_p && !r.sda_s && r.sda_p;
  assign stop_seen = r.scl_s && r.scl_p && r.sda_s && !r.sda_p;

  // two-wire slave engine
  always_comb begin
    n = r;
    // reset and pin synchronisers
    n.rs_m = rst;
    n.rs_s = r.rs_m;
    n.scl_m = scl_in;
    n.scl_s = r.scl_m;
    n.scl_p = r.scl_s;
    n.sda_m = sda_in;
    n.sda_s = r.sda_m;
    n.sda_p = r.sda_s;
    n.ack_m = x.ack_tgl;
    n.ack_s = r.ack_m;
    n.ack_p = r.ack_s;
    // read data returning from the system side
    if (r.ack_s != r.ack_p) begin
      n.rd_buf = x.ack_rdata;
    end
    // link reset clears the engine; synchronisers keep running
    if (link_rst) begin
      n.st = ST_IDLE;
      n.ph = PH_SLAVE;
      n.bitc = '0;
      n.rw = 1'b0;
      n.shf = '0;
      n.reg_addr = '0;
      n.rd_buf = '0;
      n.drive = 1'b0;
      n.req_tgl = 1'b0;
      n.req_we = 1'b0;
      n.req_addr = '0;
      n.req_wdata = '0;
    end else if (spi_mode) begin
      // four-wire port owns the pins: stay idle, never pull data
      n.st = ST_IDLE;
      n.drive = 1'b0;
    end else if (start_seen) begin
      // start or repeated start drops any partial byte
      n.st = ST_RX;
      n.ph = PH_SLAVE;
      n.bitc = '0;
      n.drive = 1'b0;
    end else if (stop_seen) begin
      // stop ends the frame wherever it falls
      n.st = ST_IDLE;
      n.bitc = '0;
      n.drive = 1'b0;
    end else begin
      case (r.st)
        ST_RX: begin
          if (scl_rise) begin
            n.shf = {r.shf[DATA_W-2:0], r.sda_s};
            n.bitc = r.bitc + 4'h1;
          end else if (scl_fall && r.bitc == BIT_LAST) begin
            n.bitc = '0;
            n.st = ST_RX_ACK;
            n.drive = 1'b1;
            case (r.ph)
              PH_SLAVE: begin
                // address byte: answer only our own address
                if (r.shf[DATA_W-1:1] == slave_addr) begin
                  n.rw = r.shf[0];
                  n.ph = PH_ADDR_HI;
                  if (r.shf[0] == RW_READ) begin
                    // fetch the first read byte during the acknowledge
                    n.req_we = 1'b0;
                    n.req_addr = r.reg_addr;
                    n.req_tgl = ~r.req_tgl;
                  end
                end else begin
                  n.st = ST_IDLE;
                  n.drive = 1'b0;
                end
              end
              PH_ADDR_HI: begin
                // register address, high byte first
                n.reg_addr = {r.shf, r.reg_addr[DATA_W-1:0]};
                n.ph = PH_ADDR_LO;
              end
              PH_ADDR_LO: begin
                // low byte completes the register address
                n.reg_addr = {r.reg_addr[REG_ADDR_W-1:DATA_W], r.shf};
                n.ph = PH_DATA;
              end
              default: begin
                // data byte: one write access, then step the address
                n.req_we = 1'b1;
                n.req_addr = r.reg_addr;
                n.req_wdata = r.shf;
                n.req_tgl = ~r.req_tgl;
                n.reg_addr = r.reg_addr + REG_ADDR_STEP;
              end
            endcase
          end
        end
        ST_RX_ACK: begin
          // acknowledge held through the ninth pulse; on its fall a write releases data, a read drives its first bit
          if (scl_fall) begin
            n.bitc = '0;
            if (r.rw == RW_READ) begin
              n.st = ST_TX;
              n.shf = r.rd_buf;
              n.drive = ~r.rd_buf[DATA_W-1];
              n.reg_addr = r.reg_addr + REG_ADDR_STEP;
              n.req_we = 1'b0;
              n.req_addr = r.reg_addr + REG_ADDR_STEP;
              n.req_tgl = ~r.req_tgl;
            end else begin
              n.st = ST_RX;
              n.drive = 1'b0;
            end
          end
        end
        ST_TX: begin
          // next bit goes out just after each falling clock
          if (scl_fall) begin
            if (r.bitc == TX_BIT_LAST) begin
              n.bitc = '0;
              n.drive = 1'b0;
              n.st = ST_TX_ACK;
            end else begin
              n.shf = {r.shf[DATA_W-2:0], 1'b0};
              n.drive = ~r.shf[DATA_W-2];
              n.bitc = r.bitc + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          // master answer: released data is a no-acknowledge
          if (scl_rise && r.sda_s) begin
            n.st = ST_IDLE;
            n.drive = 1'b0;
          end else if (scl_fall) begin
            // master acknowledged: send the prefetched byte, fetch another
            n.st = ST_TX;
            n.bitc = '0;
            n.shf = r.rd_buf;
            n.drive = ~r.rd_buf[DATA_W-1];
            n.reg_addr = r.reg_addr + REG_ADDR_STEP;
            n.req_we = 1'b0;
            n.req_addr = r.reg_addr + REG_ADDR_STEP;
            n.req_tgl = ~r.req_tgl;
          end
        end
        default: begin
          n.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    r <= n;
  end

  // carrier towards the system side
  assign x.req_tgl = r.req_tgl;
  assign x.req_we = r.req_we;
  assign x.req_addr = r.req_addr;
  assign x.req_wdata = r.req_wdata;
  assign x.spi_mode = spi_mode;

  // open-drain data pin; the clock pin is input only
  assign sda_out = 1'b0;
  assign sda_oe = r.drive;

endmodule

`default_nettype wire

/* verif/spsi_i2c_slave_monitor.sv */
// checker of the two-wire slave front end, sees only top ports
// bound into every instance of the top module
`default_nettype none

module spsi_i2c_slave_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] port_strap_high,
  input wire logic [1:0] port_strap_low,
  input wire logic sleep_request_n,
  input wire logic spi_select,
  input wire logic sleep_active,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [spsi_pkg::REG_ADDR_W-1:0] cfg_addr,
  input wire logic [spsi_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic cfg_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  import spsi_pkg::*;

  // link side: open drain, data moves only while clock low
  a_oe_open_drain: assert property (@(posedge link_clk) disable iff (rst)
    sda_oe |-> !sda_out) else $error("data pin driven high");
  a_edge_clk_low: assert property (@(posedge link_clk) disable iff (rst)
    $changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");

  // port choice against the straps
  a_spi_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    spi_select |-> !sda_oe) else $error("data driven in four-wire mode");
  a_spi_straps: assert property (@(posedge sys_clk) disable iff (rst)
    spi_select |-> port_strap_high == STRAP_HIGH && port_strap_low == STRAP_HIGH)
    else $error("four-wire mode with a strap not high");

  // configuration access handshake
  a_cfg_hold: assert property (@(posedge sys_clk) disable iff (rst)
    cfg_req && !cfg_ack |=> cfg_req && $stable(cfg_addr) && $stable(cfg_we)
    && $stable(cfg_wdata)) else $error("access changed before answer");
  a_cfg_end: assert property (@(posedge sys_clk) disable iff (rst)
    cfg_req && cfg_ack |=> !cfg_req) else $error("access held after answer");
  a_cfg_gap: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(cfg_req) |-> !cfg_req [*2]) else $error("accesses too close");

  // sleep flag follows the pin, port keeps working
  a_sleep_set: assert property (@(posedge sys_clk) disable iff (rst)
    !sleep_request_n [*4] |-> sleep_active) else $error("sleep flag missing");
  a_sleep_clear: assert property (@(posedge sys_clk) disable iff (rst)
    sleep_request_n && $past(sleep_request_n) && $past(sleep_request_n, 2) |-> !sleep_active)
    else $error("sleep flag without the pin");

  // main scenarios seen
  c_write: cover property (@(posedge sys_clk) cfg_req && cfg_ack && cfg_we);
  c_read_sleep: cover property (@(posedge sys_clk) cfg_req && !cfg_we && sleep_active);
  c_spi: cover property (@(posedge sys_clk) spi_select);
endmodule

bind spsi_i2c_slave spsi_i2c_slave_monitor u_spsi_i2c_slave_monitor (
  .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .port_strap_high(port_strap_high),
  .port_strap_low(port_strap_low), .sleep_request_n(sleep_request_n),
  .spi_select(spi_select), .sleep_active(sleep_active), .cfg_req(cfg_req),
  .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack)
);

`default_nettype wire

/* verif/spsi_mst.sv */
// two-wire bus master model: drives the clock, pulls data low
// assumes a pull-up on data; the wire level returns on sda
`default_nettype none

module spsi_mst (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  int qtr = 630; // quarter bit in ns, sets the rate

  // clock stands high, data released between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // one clock pulse per bit, data set while clock low
  task automatic xfer(input logic b, output logic r);
    sda_low = !b;
    #(qtr);
    scl = 1'b1;
    #(qtr);
    r = sda;
    #(qtr);
    scl = 1'b0;
    #(qtr);
  endtask

  task automatic start();
    sda_low = 1'b0;
    #(qtr);
    scl = 1'b1;
    #(qtr);
    sda_low = 1'b1;
    #(qtr);
    scl = 1'b0;
    #(qtr);
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #(qtr);
    scl = 1'b1;
    #(qtr);
    sda_low = 1'b0;
    #(qtr);
  endtask

  // msb first, then the acknowledge slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
    end
    xfer(1'b1, r);
    ack = !r;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      d[i] = r;
    end
    xfer(!ack, r);
  endtask
endmodule

`default_nettype wire

/* verif/spsi_i2c_slave_test.sv */
// self-checking bench of the two-wire slave front end
// answers configuration accesses itself; master model drives the bus
`default_nettype none

module spsi_i2c_slave_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spsi_pkg::*;

  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] strap_hi = STRAP_OPEN;
  logic [1:0] strap_lo = STRAP_OPEN;
  logic sleep_n = 1'b1;
  logic cfg_ack = 1'b0;
  logic [DATA_W-1:0] cfg_rdata = 8'h00;
  logic scl, sda_low, sda_out, sda_oe, spi_select, sleep_active, cfg_req, cfg_we, ack;
  logic [REG_ADDR_W-1:0] cfg_addr;
  logic [DATA_W-1:0] cfg_wdata;
  wire logic sda_w = !(sda_oe | sda_low);
  logic [23:0] wq[$];
  int num_errors = 0;
  int n_compared = 0;

  // system and link clocks, unrelated phase
  initial begin
    forever #5 sys_clk = !sys_clk;
  end
  initial begin
    #3.3;
    forever #7.5 link_clk = !link_clk;
  end

  spsi_i2c_slave #(.LINK_CLK_MHZ(66)) u_spsi_i2c_slave (
    .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .port_strap_high(strap_hi),
    .port_strap_low(strap_lo), .sleep_request_n(sleep_n), .spi_select(spi_select),
    .sleep_active(sleep_active), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack)
  );
  spsi_mst u_spsi_mst (.scl(scl), .sda_low(sda_low), .sda(sda_w));

  // one-cycle answer, read data derived from the address
  always @(negedge sys_clk) begin
    if (cfg_ack) begin
      cfg_ack = 1'b0;
    end else if (cfg_req === 1'b1) begin
      cfg_ack = 1'b1;
      cfg_rdata = cfg_addr[7:0] ^ 8'h5a;
      if (cfg_we) begin
        wq.push_back({cfg_addr, cfg_wdata});
      end
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
    @(negedge sys_clk);
    strap_hi = hi;
    strap_lo = lo;
    rst = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (30) @(negedge sys_clk);
  endtask

  // every strap pair: port choice and the answering address
  task automatic t_straps();
    for (int i = 0; i < 9; i++) begin
      do_reset(2'(i / 3), 2'(i % 3));
      chk(24'(spi_select), 24'(i == 8));
      u_spsi_mst.start();
      u_spsi_mst.wbyte({SLAVE_ADDR_MSB, 3'(i), 1'b0}, ack);
      u_spsi_mst.stop();
      chk(24'(ack), 24'(i != 8));
    end
  endtask

  // refused address, burst write, partial byte cut by stop
  task automatic t_write();
    logic [7:0] b[5] = '{8'hb8, 8'h12, 8'h34, 8'ha5, 8'h3c};
    logic r;
    wq.delete();
    u_spsi_mst.start();
    u_spsi_mst.wbyte(8'ha8, ack);
    chk(24'(ack), 24'h0);
    u_spsi_mst.start();
    foreach (b[i]) begin
      u_spsi_mst.wbyte(b[i], ack);
      chk(24'(ack), 24'h1);
    end
    repeat (3) u_spsi_mst.xfer(1'b1, r);
    u_spsi_mst.stop();
    repeat (20) @(negedge sys_clk);
    chk(24'(wq.size()), 24'h2);
    chk(wq[0], 24'h12_34a5);
    chk(wq[1], 24'h12_353c);
  endtask

  // slow read during sleep, continues at the next address
  task automatic t_read();
    logic [7:0] d0;
    logic [7:0] d1;
    u_spsi_mst.qtr = 2500;
    @(negedge sys_clk);
    sleep_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk(24'(sleep_active), 24'h1);
    u_spsi_mst.start();
    u_spsi_mst.wbyte(8'hb9, ack);
    chk(24'(ack), 24'h1);
    u_spsi_mst.rbyte(1'b1, d0);
    u_spsi_mst.rbyte(1'b0, d1);
    u_spsi_mst.stop();
    chk(24'(d0), 24'(8'h36 ^ 8'h5a));
    chk(24'(d1), 24'(8'h37 ^ 8'h5a));
    @(negedge sys_clk);
    sleep_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk(24'(sleep_active), 24'h0);
  endtask

  initial begin
    do_reset(STRAP_OPEN, STRAP_OPEN);
    t_straps();
    do_reset(STRAP_OPEN, STRAP_OPEN);
    t_write();
    t_read();
    summarize();
  end

  // hang guard
  initial begin
    #1000000;
    num_errors++;
    summarize();
  end
endmodule

`default_nettype wire
